// *** core/asm_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module asm_monitor
	import asm_pkg::*;
#(
	parameter int MAG_W = ASM_THRESH_W
)(
	input  wire logic                  clock,
	input  wire logic                  srst,
	input  wire logic                  ce,
	input  wire logic [ASM_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [ASM_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic      [1:0]            s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [ASM_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic      [ASM_DATA_W-1:0] s_axi_rdata,
	output logic      [1:0]            s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  sample_valid,
	input  wire logic [MAG_W-1:0]      sample_magnitude,
	input  wire logic [MAG_W-1:0]      upper_threshold,
	input  wire logic [MAG_W-1:0]      lower_threshold,
	input  wire logic                  sysref_edge,
	input  wire logic                  sysref_enable,
	output logic                       threshold_flag_pin
);

	// Write channel holding state.
	logic                  aw_held_reg;
	logic [ASM_IDX_W-1:0]  wr_idx_reg;
	logic                  w_held_reg;
	logic [7:0]            wr_byte_reg;
	logic                  wr_lane_reg;
	logic                  do_write;
	logic                  wr_en;

	// Register storage.
	logic [7:0]              dwell_low_reg;
	logic [7:0]              dwell_high_reg;
	logic                    sync_mode_reg;
	logic                    peak_en_reg;
	logic [ASM_PERIOD_W-1:0] period_reg;
	logic [ASM_SEL_W-1:0]    sel_reg;
	logic                    update_reg;
	logic [ASM_RESULT_W-1:0] result_reg;
	logic [ASM_FRAME_W-1:0]  frame_reg;

	// Monitor and flag state.
	logic [ASM_RESULT_W-1:0] peak_value;
	logic [ASM_RESULT_W-1:0] selected;
	logic [ASM_RESULT_W-1:0] mag_wide;
	logic                    window_done;
	logic                    realign;
	asm_fd_state_t           fd_state_reg;
	logic [ASM_DWELL_W-1:0]  dwell_cnt_reg;
	logic [ASM_DWELL_W-1:0]  dwell_target;
	logic                    above_upper;
	logic                    below_lower;

	// Read side.
	logic [7:0]            rd_byte;
	logic [ASM_IDX_W-1:0]  rd_idx;

	// A write is carried out once address and data are both held.
	assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign wr_en    = do_write && wr_lane_reg;

	// Write address channel; ready only while no address or response is pending.
	always_ff @(posedge clock) begin
		if (srst) begin
			aw_held_reg   <= 1'b0;
			wr_idx_reg    <= '0;
			s_axi_awready <= 1'b0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg   <= 1'b1;
				wr_idx_reg    <= asm_reg_index(s_axi_awaddr);
				s_axi_awready <= 1'b0;
			end else if (do_write) begin
				aw_held_reg <= 1'b0;
			end else if (!aw_held_reg && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
		end
	end

	// Write data channel; only byte lane 0 carries register data.
	always_ff @(posedge clock) begin
		if (srst) begin
			w_held_reg   <= 1'b0;
			wr_byte_reg  <= '0;
			wr_lane_reg  <= 1'b0;
			s_axi_wready <= 1'b0;
		end else if (ce) begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg   <= 1'b1;
				wr_byte_reg  <= s_axi_wdata[7:0];
				wr_lane_reg  <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end else if (do_write) begin
				w_held_reg <= 1'b0;
			end else if (!w_held_reg && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Write response; unmapped indices answer with a slave error.
	always_ff @(posedge clock) begin
		if (srst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= ASM_RESP_OKAY;
		end else if (ce) begin
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= asm_reg_mapped(wr_idx_reg) ?
				                ASM_RESP_OKAY : ASM_RESP_SLVERR;
			end else if (s_axi_bready && s_axi_bvalid) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Dwell target bytes.
	always_ff @(posedge clock) begin
		if (srst) begin
			dwell_low_reg  <= '0;
			dwell_high_reg <= '0;
		end else if (ce && wr_en) begin
			if (wr_idx_reg == ASM_IDX_DWELL_LOW) begin
				dwell_low_reg <= wr_byte_reg;
			end
			if (wr_idx_reg == ASM_IDX_DWELL_HIGH) begin
				dwell_high_reg <= wr_byte_reg;
			end
		end
	end

	// A realignment needs an armed bit and an enabled reference input.
	assign realign = sync_mode_reg && sysref_edge && sysref_enable;

	// Sync mode bit; a software write of 1 wins over the self clear.
	always_ff @(posedge clock) begin
		if (srst) begin
			sync_mode_reg <= 1'b0;
		end else if (ce) begin
			if (wr_en && (wr_idx_reg == ASM_IDX_SYNC_CTRL)) begin
				sync_mode_reg <= wr_byte_reg[ASM_SYNC_MODE_BIT];
			end else if (realign) begin
				sync_mode_reg <= 1'b0;
			end
		end
	end

	// Peak detector enable; other bits of this byte are not stored.
	always_ff @(posedge clock) begin
		if (srst) begin
			peak_en_reg <= 1'b0;
		end else if (ce && wr_en && (wr_idx_reg == ASM_IDX_MON_CTRL)) begin
			peak_en_reg <= wr_byte_reg[ASM_PEAK_EN_BIT];
		end
	end

	// Window period across three bytes.
	always_ff @(posedge clock) begin
		if (srst) begin
			period_reg <= {16'h0000, ASM_PERIOD0_RST};
		end else if (ce && wr_en) begin
			case (wr_idx_reg)
				ASM_IDX_PERIOD0: period_reg[7:0]   <= wr_byte_reg;
				ASM_IDX_PERIOD1: period_reg[15:8]  <= wr_byte_reg;
				ASM_IDX_PERIOD2: period_reg[23:16] <= wr_byte_reg;
				default:         period_reg        <= period_reg;
			endcase
		end
	end

	// Result selection and the self-clearing update request.
	always_ff @(posedge clock) begin
		if (srst) begin
			sel_reg    <= ASM_SEL_RST;
			update_reg <= 1'b0;
		end else if (ce) begin
			if (wr_en && (wr_idx_reg == ASM_IDX_RESULT_CTRL)) begin
				sel_reg <= wr_byte_reg[ASM_SEL_W-1:0];
			end
			if (wr_en && (wr_idx_reg == ASM_IDX_RESULT_CTRL) &&
			    wr_byte_reg[ASM_UPDATE_BIT]) begin
				update_reg <= 1'b1;
			end else if (update_reg) begin
				update_reg <= 1'b0;
			end
		end
	end

	// Source picked by the current selection code.
	always_comb begin
		if (sel_reg == ASM_SEL_PEAK) begin
			selected = peak_value;
		end else begin
			selected = '0;
		end
	end

	// Result registers load only on an update request.
	always_ff @(posedge clock) begin
		if (srst) begin
			result_reg <= '0;
		end else if (ce && update_reg) begin
			result_reg <= selected;
		end
	end

	// Frame counter steps at each window expiry.
	always_ff @(posedge clock) begin
		if (srst) begin
			frame_reg <= '0;
		end else if (ce && window_done) begin
			frame_reg <= frame_reg + 8'h01;
		end
	end

	assign mag_wide = ASM_RESULT_W'(sample_magnitude);

	// Peak detector over the programmed window.
	asm_peak u_peak (
		.clock        (clock),
		.srst         (srst),
		.ce           (ce),
		.enable       (peak_en_reg),
		.restart      (realign),
		.period       (period_reg),
		.sample_valid (sample_valid),
		.magnitude    (mag_wide),
		.peak_result  (peak_value),
		.expire       (window_done)
	);

	// Threshold comparisons on valid samples only.
	assign above_upper  = sample_valid && (sample_magnitude > upper_threshold);
	assign below_lower  = sample_valid && (sample_magnitude < lower_threshold);
	assign dwell_target = {dwell_high_reg, dwell_low_reg};

	// Threshold flag: set above the upper level, released after dwell.
	always_ff @(posedge clock) begin
		if (srst) begin
			fd_state_reg       <= ASM_FD_LOW;
			dwell_cnt_reg      <= '0;
			threshold_flag_pin <= 1'b0;
		end else if (ce) begin
			case (fd_state_reg)
				ASM_FD_LOW: begin
					if (above_upper) begin
						fd_state_reg       <= ASM_FD_HIGH;
						threshold_flag_pin <= 1'b1;
					end
				end
				ASM_FD_HIGH: begin
					if (below_lower) begin
						if (dwell_target <= 16'h0001) begin
							fd_state_reg       <= ASM_FD_LOW;
							threshold_flag_pin <= 1'b0;
						end else begin
							fd_state_reg  <= ASM_FD_DWELL;
							dwell_cnt_reg <= dwell_target - 16'h0001;
						end
					end
				end
				ASM_FD_DWELL: begin
					if (sample_valid && !below_lower) begin
						fd_state_reg <= ASM_FD_HIGH;
					end else if (below_lower) begin
						if (dwell_cnt_reg == 16'h0001) begin
							fd_state_reg       <= ASM_FD_LOW;
							threshold_flag_pin <= 1'b0;
						end else begin
							dwell_cnt_reg <= dwell_cnt_reg - 16'h0001;
						end
					end
				end
				default: begin
					fd_state_reg       <= ASM_FD_LOW;
					threshold_flag_pin <= 1'b0;
				end
			endcase
		end
	end

	assign rd_idx = asm_reg_index(s_axi_araddr);

	// Read decode; reserved bits read as zero.
	always_comb begin
		case (rd_idx)
			ASM_IDX_DWELL_LOW:   rd_byte = dwell_low_reg;
			ASM_IDX_DWELL_HIGH:  rd_byte = dwell_high_reg;
			ASM_IDX_SYNC_CTRL:   rd_byte = {7'h00, sync_mode_reg};
			ASM_IDX_MON_CTRL:    rd_byte = {6'h00, peak_en_reg, 1'b0};
			ASM_IDX_PERIOD0:     rd_byte = period_reg[7:0];
			ASM_IDX_PERIOD1:     rd_byte = period_reg[15:8];
			ASM_IDX_PERIOD2:     rd_byte = period_reg[23:16];
			ASM_IDX_RESULT_CTRL: rd_byte = {3'h0, update_reg, 1'b0, sel_reg};
			ASM_IDX_RESULT0:     rd_byte = result_reg[7:0];
			ASM_IDX_RESULT1:     rd_byte = result_reg[15:8];
			ASM_IDX_RESULT2:     rd_byte = {4'h0, result_reg[19:16]};
			ASM_IDX_FRAME_CNT:   rd_byte = frame_reg;
			default:             rd_byte = 8'h00;
		endcase
	end

	// Read channel; the data register loads at address acceptance.
	always_ff @(posedge clock) begin
		if (srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= ASM_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= {24'h000000, rd_byte};
				s_axi_rresp   <= asm_reg_mapped(rd_idx) ?
				                 ASM_RESP_OKAY : ASM_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// *** common/asm_pkg.sv ***
package asm_pkg;

	// Bus geometry.
	localparam int ASM_DATA_W = 32;
	localparam int ASM_ADDR_W = 12;
	localparam int ASM_IDX_W  = 10;

	// Register indices; the byte address is four times the index.
	localparam logic [9:0] ASM_IDX_DWELL_LOW   = 10'h24B;
	localparam logic [9:0] ASM_IDX_DWELL_HIGH  = 10'h24C;
	localparam logic [9:0] ASM_IDX_SYNC_CTRL   = 10'h26F;
	localparam logic [9:0] ASM_IDX_MON_CTRL    = 10'h270;
	localparam logic [9:0] ASM_IDX_PERIOD0     = 10'h271;
	localparam logic [9:0] ASM_IDX_PERIOD1     = 10'h272;
	localparam logic [9:0] ASM_IDX_PERIOD2     = 10'h273;
	localparam logic [9:0] ASM_IDX_RESULT_CTRL = 10'h274;
	localparam logic [9:0] ASM_IDX_RESULT0     = 10'h275;
	localparam logic [9:0] ASM_IDX_RESULT1     = 10'h276;
	localparam logic [9:0] ASM_IDX_RESULT2     = 10'h277;
	localparam logic [9:0] ASM_IDX_FRAME_CNT   = 10'h278;

	// Field positions.
	localparam int ASM_SYNC_MODE_BIT = 0;
	localparam int ASM_PEAK_EN_BIT   = 1;
	localparam int ASM_UPDATE_BIT    = 4;

	// Widths.
	localparam int ASM_RESULT_W = 20;
	localparam int ASM_PERIOD_W = 24;
	localparam int ASM_DWELL_W  = 16;
	localparam int ASM_THRESH_W = 13;
	localparam int ASM_SEL_W    = 3;
	localparam int ASM_FRAME_W  = 8;

	// Reset values and codes.
	localparam logic [7:0] ASM_PERIOD0_RST = 8'h80;
	localparam logic [2:0] ASM_SEL_RST     = 3'h1;
	localparam logic [2:0] ASM_SEL_PEAK    = 3'h1;
	localparam logic [23:0] ASM_PERIOD_MIN = 24'h000002;

	// Bus responses.
	localparam logic [1:0] ASM_RESP_OKAY   = 2'h0;
	localparam logic [1:0] ASM_RESP_SLVERR = 2'h2;

	// Threshold flag states, Gray coded on every step except DWELL to LOW.
	typedef enum logic [1:0] {
		ASM_FD_LOW   = 2'h0,
		ASM_FD_HIGH  = 2'h1,
		ASM_FD_DWELL = 2'h3
	} asm_fd_state_t;

	// Word index from a byte address.
	function automatic logic [9:0] asm_reg_index(input logic [11:0] a);
		return a[11:2];
	endfunction

	// True when an index names a register of this block.
	function automatic logic asm_reg_mapped(input logic [9:0] i);
		return (i == ASM_IDX_DWELL_LOW) || (i == ASM_IDX_DWELL_HIGH) ||
		       (i == ASM_IDX_SYNC_CTRL) ||
		       ((i >= ASM_IDX_MON_CTRL) && (i <= ASM_IDX_FRAME_CNT));
	endfunction

endpackage

// *** core/asm_peak.sv ***
`timescale 1ns/1ps
`default_nettype none
module asm_peak
	import asm_pkg::*;
(
	input  wire logic                    clock,
	input  wire logic                    srst,
	input  wire logic                    ce,
	input  wire logic                    enable,
	input  wire logic                    restart,
	input  wire logic [ASM_PERIOD_W-1:0] period,
	input  wire logic                    sample_valid,
	input  wire logic [ASM_RESULT_W-1:0] magnitude,
	output logic      [ASM_RESULT_W-1:0] peak_result,
	output logic                         expire
);

	logic [ASM_PERIOD_W-1:0] count_reg;
	logic [ASM_RESULT_W-1:0] acc_reg;
	logic [ASM_PERIOD_W-1:0] eff_period;
	logic [ASM_PERIOD_W-1:0] last_count;
	logic [ASM_RESULT_W-1:0] cur_mag;

	// Larger of two magnitudes.
	function automatic logic [ASM_RESULT_W-1:0] mag_max(
		input logic [ASM_RESULT_W-1:0] a,
		input logic [ASM_RESULT_W-1:0] b);
		return (a > b) ? a : b;
	endfunction

	// Even period with bit 0 dropped, never shorter than two cycles.
	always_comb begin
		eff_period = {period[ASM_PERIOD_W-1:1], 1'b0};
		if (eff_period < ASM_PERIOD_MIN) begin
			eff_period = ASM_PERIOD_MIN;
		end
		last_count = eff_period - ASM_PERIOD_MIN + 24'h000001;
		cur_mag = sample_valid ? magnitude : '0;
	end

	// Window counter and running peak; a restart realigns the window.
	always_ff @(posedge clock) begin
		if (srst) begin
			count_reg   <= '0;
			acc_reg     <= '0;
			peak_result <= '0;
			expire      <= 1'b0;
		end else if (ce) begin
			expire <= 1'b0;
			if (restart || !enable) begin
				count_reg <= '0;
				acc_reg   <= '0;
			end else if (count_reg >= last_count) begin
				count_reg   <= '0;
				expire      <= 1'b1;
				peak_result <= mag_max(acc_reg, cur_mag);
				acc_reg     <= '0;
			end else begin
				count_reg <= count_reg + 24'h000001;
				acc_reg   <= mag_max(acc_reg, cur_mag);
			end
		end
	end

endmodule
`default_nettype wire

// *** bench/asm_monitor_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module asm_monitor_monitor
	import asm_pkg::*;
#(
	parameter int MAG_W = ASM_THRESH_W
)(
	input wire logic                  clock,
	input wire logic                  srst,
	input wire logic                  ce,
	input wire logic                  s_axi_awvalid,
	input wire logic                  s_axi_awready,
	input wire logic                  s_axi_wvalid,
	input wire logic                  s_axi_wready,
	input wire logic [1:0]            s_axi_bresp,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic [ASM_ADDR_W-1:0] s_axi_araddr,
	input wire logic                  s_axi_arvalid,
	input wire logic                  s_axi_arready,
	input wire logic [ASM_DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0]            s_axi_rresp,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_rready,
	input wire logic                  sample_valid,
	input wire logic [MAG_W-1:0]      sample_magnitude,
	input wire logic [MAG_W-1:0]      upper_threshold,
	input wire logic [MAG_W-1:0]      lower_threshold,
	input wire logic                  threshold_flag_pin
);
	logic [ASM_IDX_W-1:0] ar_idx_reg;

	default clocking @(posedge clock); endclocking
	default disable iff (srst);

	// Remembers which register the pending read names.
	always_ff @(posedge clock) begin
		if (srst) begin
			ar_idx_reg <= '0;
		end else if (ce && s_axi_arvalid && s_axi_arready) begin
			ar_idx_reg <= s_axi_araddr[11:2];
		end
	end

	// Steps of a write and of the flag path.
	sequence s_write_taken;
		ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_over_upper;
		sample_valid && (sample_magnitude > upper_threshold);
	endsequence
	sequence s_not_quiet;
		!(sample_valid && (sample_magnitude < lower_threshold));
	endsequence

	property p_write_answer;
		s_write_taken |-> ##2 s_axi_bvalid;
	endproperty
	property p_bresp_stands;
		ce && s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_read_answer;
		ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	property p_rdata_stands;
		ce && s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_upper_zero;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	property p_nibble_zero;
		s_axi_rvalid && (ar_idx_reg == ASM_IDX_RESULT2) |-> s_axi_rdata[7:4] == 4'h0;
	endproperty
	property p_ctrl_reserved;
		s_axi_rvalid && (ar_idx_reg == ASM_IDX_MON_CTRL) |-> (s_axi_rdata[7:0] & 8'hFD) == 8'h00;
	endproperty
	property p_flag_rise;
		ce && !threshold_flag_pin ##0 s_over_upper |=> threshold_flag_pin;
	endproperty
	property p_flag_hold;
		ce && threshold_flag_pin ##0 s_not_quiet |=> threshold_flag_pin;
	endproperty

	a_write_answer: assert property (p_write_answer)
		else $error("write answer missing");
	a_bresp_stands: assert property (p_bresp_stands)
		else $error("write response dropped");
	a_read_answer: assert property (p_read_answer)
		else $error("read answer missing");
	a_rdata_stands: assert property (p_rdata_stands)
		else $error("read data dropped");
	a_upper_zero: assert property (p_upper_zero)
		else $error("upper read bits not zero");
	a_nibble_zero: assert property (p_nibble_zero)
		else $error("result top nibble not zero");
	a_ctrl_reserved: assert property (p_ctrl_reserved)
		else $error("control reserved bits not zero");
	a_flag_rise: assert property (p_flag_rise)
		else $error("flag did not rise");
	a_flag_hold: assert property (p_flag_hold)
		else $error("flag released without quiet sample");
endmodule

bind asm_monitor asm_monitor_monitor #(.MAG_W(MAG_W)) u_monitor (.clock, .srst, .ce,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_valid,
	.sample_magnitude, .upper_threshold, .lower_threshold, .threshold_flag_pin);
`default_nettype wire

// *** bench/asm_monitor_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module asm_monitor_test
	import asm_pkg::*;
;
	logic                  clock = 1'h0;
	logic                  srst, ce, s_axi_awvalid, s_axi_awready;
	logic                  s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic                  sample_valid, sysref_edge, sysref_enable, threshold_flag_pin;
	logic [ASM_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [ASM_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]            s_axi_wstrb;
	logic [1:0]            s_axi_bresp, s_axi_rresp;
	logic [12:0]           sample_magnitude, upper_threshold, lower_threshold;
	logic [7:0]            q, f0;
	logic                  slow_ack;
	int                    err_count, tests_run;
	logic [9:0]            ridx [9] = '{ASM_IDX_DWELL_HIGH, ASM_IDX_SYNC_CTRL,
		ASM_IDX_MON_CTRL, ASM_IDX_PERIOD0, ASM_IDX_PERIOD1, ASM_IDX_PERIOD2,
		ASM_IDX_RESULT_CTRL, ASM_IDX_RESULT0, ASM_IDX_RESULT1};
	logic [7:0]            rval [9] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00,
		8'h01, 8'h00, 8'h00};

	asm_monitor u_dut (.clock, .srst, .ce, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.sample_valid, .sample_magnitude, .upper_threshold, .lower_threshold,
		.sysref_edge, .sysref_enable, .threshold_flag_pin);

	// The clock turns over every half period of 25 ns.
	always #25 clock = ~clock;

	// Counts a comparison and reports a miss.
	task automatic check(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'h1) begin
			err_count++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic print_verdict();
		$display("checks run %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// One bus access; each channel is released at the edge that takes it.
	// With slow_ack set, the response ready rises only once valid is seen.
	task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] d,
		input logic [1:0] er, input logic ck, input logic [7:0] ed);
		int n;
		logic ta, tw, tr, done, hv;
		n = 0;
		done = 1'h0;
		@(posedge clock);
		s_axi_awaddr <= {i, 2'h0};
		s_axi_araddr <= {i, 2'h0};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w && !slow_ack;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w && !slow_ack;
		while (!done && n < 100) begin
			@(negedge clock);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tr = s_axi_arvalid && s_axi_arready;
			hv = w ? s_axi_bvalid : s_axi_rvalid;
			done = hv && (w ? s_axi_bready : s_axi_rready);
			q = s_axi_rdata[7:0];
			if (done) begin
				check((w ? s_axi_bresp : s_axi_rresp) === er, "response");
				if (ck) check(s_axi_rdata === {24'h000000, ed}, "read data");
			end
			n++;
			@(posedge clock);
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
			if (tr) s_axi_arvalid <= 1'h0;
			if (done) s_axi_bready <= 1'h0;
			if (done) s_axi_rready <= 1'h0;
			if (hv && !done) begin
				s_axi_bready <= w;
				s_axi_rready <= !w;
			end
		end
		if (!done) check(1'h0, "bus timeout");
	endtask

	task automatic wr(input logic [9:0] i, input logic [7:0] d);
		bus(1'h1, i, d, ASM_RESP_OKAY, 1'h0, 8'h00);
	endtask

	task automatic rd(input logic [9:0] i, input logic [7:0] e);
		bus(1'h0, i, 8'h00, ASM_RESP_OKAY, 1'h1, e);
	endtask

	// Presents one sample for k cycles.
	task automatic feed(input logic [12:0] m, input logic v, input int k);
		repeat (k) begin
			@(posedge clock);
			sample_magnitude <= m;
			sample_valid <= v;
		end
	endtask

	// One reference edge, with the reference input enabled or not.
	task automatic pulse(input logic en);
		@(posedge clock);
		sysref_enable <= en;
		sysref_edge <= 1'h1;
		@(posedge clock);
		sysref_edge <= 1'h0;
	endtask

	// Main sequence.
	initial begin
		{ce, srst} = 2'h3;
		slow_ack = 1'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
		{s_axi_rready, sample_valid, sysref_edge, sysref_enable} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		sample_magnitude = 13'h0000;
		upper_threshold = 13'h1000;
		lower_threshold = 13'h0100;
		err_count = 0;
		tests_run = 0;
		repeat (20) @(posedge clock);
		srst <= 1'h0;
		for (int k = 0; k < 9; k++) rd(ridx[k], rval[k]);
		bus(1'h0, 10'h100, 8'h00, ASM_RESP_SLVERR, 1'h1, 8'h00);
		bus(1'h1, 10'h100, 8'h5A, ASM_RESP_SLVERR, 1'h0, 8'h00);
		// Late ready: each answer must stand until it is taken.
		slow_ack = 1'h1;
		wr(ASM_IDX_DWELL_HIGH, 8'hA5);
		rd(ASM_IDX_DWELL_HIGH, 8'hA5);
		slow_ack = 1'h0;
		wr(ASM_IDX_SYNC_CTRL, 8'hFE);
		rd(ASM_IDX_SYNC_CTRL, 8'h00);
		wr(ASM_IDX_RESULT0, 8'hFF);
		rd(ASM_IDX_RESULT0, 8'h00);
		wr(ASM_IDX_MON_CTRL, 8'hFF);
		rd(ASM_IDX_MON_CTRL, 8'h02);
		// A dwell target of 256 quiet samples; a loud sample restarts it.
		wr(ASM_IDX_DWELL_HIGH, 8'h01);
		wr(ASM_IDX_DWELL_LOW, 8'h00);
		feed(13'h1800, 1'h1, 1);
		feed(13'h0010, 1'h1, 255);
		feed(13'h0800, 1'h1, 1);
		@(negedge clock);
		check(threshold_flag_pin === 1'h1, "flag released early");
		feed(13'h0010, 1'h1, 255);
		feed(13'h0010, 1'h0, 1);
		@(negedge clock);
		check(threshold_flag_pin === 1'h1, "flag not restarted");
		feed(13'h0010, 1'h1, 1);
		feed(13'h0010, 1'h0, 1);
		@(negedge clock);
		check(threshold_flag_pin === 1'h0, "flag not released");
		// Realign a 64-cycle window and catch one peak in it.
		wr(ASM_IDX_PERIOD0, 8'h41);
		wr(ASM_IDX_SYNC_CTRL, 8'h01);
		pulse(1'h0);
		rd(ASM_IDX_SYNC_CTRL, 8'h01);
		pulse(1'h1);
		feed(13'h0010, 1'h1, 5);
		feed(13'h1ABC, 1'h1, 1);
		feed(13'h1FFF, 1'h0, 1);
		// The bit is clear now, so this edge must leave the window alone.
		pulse(1'h1);
		feed(13'h0020, 1'h1, 60);
		rd(ASM_IDX_SYNC_CTRL, 8'h00);
		wr(ASM_IDX_RESULT_CTRL, 8'h11);
		rd(ASM_IDX_RESULT_CTRL, 8'h01);
		rd(ASM_IDX_RESULT0, 8'hBC);
		rd(ASM_IDX_RESULT1, 8'h1A);
		rd(ASM_IDX_RESULT2, 8'h00);
		for (int c = 0; c < 8; c++) begin
			if (c != 1) begin
				wr(ASM_IDX_RESULT_CTRL, 8'h10 | 8'(c));
				rd(ASM_IDX_RESULT0, 8'h00);
			end
		end
		repeat (70) @(posedge clock);
		wr(ASM_IDX_RESULT_CTRL, 8'h11);
		rd(ASM_IDX_RESULT0, 8'h20);
		// A period of 3 runs as 2; the two reads are 120 edges apart.
		wr(ASM_IDX_PERIOD0, 8'h03);
		wr(ASM_IDX_SYNC_CTRL, 8'h01);
		pulse(1'h1);
		bus(1'h0, ASM_IDX_FRAME_CNT, 8'h00, ASM_RESP_OKAY, 1'h0, 8'h00);
		f0 = q;
		repeat (117) @(posedge clock);
		rd(ASM_IDX_FRAME_CNT, f0 + 8'h3C);
		// Forty frozen edges add nothing; four live edges add two frames.
		@(posedge clock);
		ce <= 1'h0;
		repeat (40) @(posedge clock);
		ce <= 1'h1;
		rd(ASM_IDX_FRAME_CNT, f0 + 8'h3E);
		wr(ASM_IDX_MON_CTRL, 8'h00);
		bus(1'h0, ASM_IDX_FRAME_CNT, 8'h00, ASM_RESP_OKAY, 1'h0, 8'h00);
		f0 = q;
		repeat (50) @(posedge clock);
		rd(ASM_IDX_FRAME_CNT, f0);
		print_verdict();
	end
endmodule
`default_nettype wire
